/* File: hw/gstmr_timer.v */
// gated sixteen bit timer with prescaler, gate unit and compare time base
`default_nettype none
`include "gstmr_consts.vh"

// What this block does
// R01 - counter value offered to capture unit
// R02 - compare match raises event when equal
// R03 - special event trigger clears whole counter
// R04 - trigger clear never sets overflow flag
// R05 - software counter write beats trigger clear
// R06 - trigger dependable only synced instruction clock
// R07 - external clock needs falling edge first
// R08 - clock source field selects four sources
// R09 - oscillator enable picks pin or crystal
// R10 - prescale divides by one two four eight
// R11 - oscillator enable drives oscillator circuit
// R12 - sync disable bypasses external clock sync; the code still takes the synchronised pin level
// R13 - timer on enables, off clears toggle
// R14 - gate enable makes counting gate dependent
// R15 - polarity selects active high or low
// R16 - toggle mode flip-flop, cleared when off
// R17 - single pulse mode controls the gate
// R18 - go done reads armed, hardware clears
// R19 - gate value bit shows gate level
// R20 - gate source field selects four sources
// R21 - writable bits reset to zero
// R22 - unimplemented control bit reads zero
// R23 - go done clears at pulse trailing edge
// R24 - gate value falling edge sets flag
// R25 - rollover to zero sets overflow flag
// R26 - eight bit overflow gives gate pulse
// R27 - counter visible as high, low bytes
module gstmr_timer (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // clock pins and oscillators
  input wire external_clock_pin,
  input wire crystal_clk,
  input wire sensing_oscillator,
  output reg secondary_osc_enable,
  // gate sources
  input wire gate_pin,
  input wire timer8_overflow,
  input wire period_match,
  input wire period10_match,
  // capture event from capture unit
  input wire capture_event,
  // time base outputs
  output reg [15:0] counter_pair,
  output reg [15:0] capture_value,
  output reg compare_event,
  output reg overflow_flag,
  output reg gate_event_flag
);
  reg [7:0] ctrl;
  reg [7:0] gate_ctrl;
  reg [15:0] cmp_pair;
  reg [2:0] ccp_ctrl;
  reg [1:0] rst_pipe;
  wire rst_n = rst_pipe[1];

  // =========================================
  // reset release through two flops
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  // =========================================
  // synchronisers for every outside level
  wire ext_lvl, ext_rise, ext_fall;
  wire xtal_lvl, xtal_rise, xtal_fall;
  wire sns_lvl, sns_rise, sns_fall;
  wire gpin_lvl, gpin_rise, gpin_fall;
  wire t8_lvl, t8_rise, t8_fall;
  wire pm_lvl, pm_rise, pm_fall;
  wire p10_lvl, p10_rise, p10_fall;
  wire cap_lvl, cap_rise, cap_fall;
  gstmr_edge_sync u_ext (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(external_clock_pin),
    .level(ext_lvl), .rise(ext_rise), .fall(ext_fall));
  gstmr_edge_sync u_xtal (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(crystal_clk),
    .level(xtal_lvl), .rise(xtal_rise), .fall(xtal_fall));
  gstmr_edge_sync u_sns (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(sensing_oscillator),
    .level(sns_lvl), .rise(sns_rise), .fall(sns_fall));
  gstmr_edge_sync u_gpin (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(gate_pin),
    .level(gpin_lvl), .rise(gpin_rise), .fall(gpin_fall));
  gstmr_edge_sync u_t8 (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(timer8_overflow),
    .level(t8_lvl), .rise(t8_rise), .fall(t8_fall));
  gstmr_edge_sync u_pm (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(period_match),
    .level(pm_lvl), .rise(pm_rise), .fall(pm_fall));
  gstmr_edge_sync u_p10 (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(period10_match),
    .level(p10_lvl), .rise(p10_rise), .fall(p10_fall));
  gstmr_edge_sync u_cap (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(capture_event),
    .level(cap_lvl), .rise(cap_rise), .fall(cap_fall));

  // =========================================
  // control fields
  wire [1:0] clock_source_select = ctrl[`GSTMR_CS_HI:`GSTMR_CS_LO];
  wire [1:0] input_prescale_select = ctrl[`GSTMR_PS_HI:`GSTMR_PS_LO];
  wire ext_clock_sync_disable = ctrl[`GSTMR_SYNC_BIT];
  wire timer_on = ctrl[`GSTMR_ON_BIT];
  wire gate_enable = gate_ctrl[`GSTMR_GE_BIT];
  wire gate_polarity = gate_ctrl[`GSTMR_GPOL_BIT];
  wire gate_toggle_mode = gate_ctrl[`GSTMR_GTM_BIT];
  wire gate_single_pulse_mode = gate_ctrl[`GSTMR_GSPM_BIT];
  wire [1:0] gate_source_select = gate_ctrl[`GSTMR_GSS_HI:`GSTMR_GSS_LO];

  // =========================================
  // external edge rebuilt from the synchronised pin level when sync is off; the pin
  // still passes both synchroniser flops, so the sync is not bypassed
  reg ext_raw_last;
  reg ext_armed;
  reg [1:0] instr_div;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_raw_last <= 1'b0;
      instr_div <= 2'h0;
    end else begin
      ext_raw_last <= ext_lvl;
      instr_div <= instr_div + 2'h1;
    end
  end

  // pick rising edge of selected source [R08] [R09] [R12]
  reg src_rise;
  reg src_fall;
  always @* begin
    src_rise = 1'b0;
    src_fall = 1'b0;
    case (clock_source_select)
      `GSTMR_CS_INSTR: src_rise = (instr_div == `GSTMR_INSTR_DIV);
      `GSTMR_CS_SYS: src_rise = 1'b1;
      `GSTMR_CS_EXT: begin
        if (secondary_osc_enable) begin
          src_rise = xtal_rise;
          src_fall = xtal_fall;
        end else if (ext_clock_sync_disable) begin
          src_rise = ext_lvl & ~ext_raw_last;
          src_fall = ~ext_lvl & ext_raw_last;
        end else begin
          src_rise = ext_rise;
          src_fall = ext_fall;
        end
      end
      `GSTMR_CS_SENSE: begin
        src_rise = sns_rise;
        src_fall = sns_fall;
      end
      default: src_rise = 1'b0;
    endcase
  end

  // external counting waits for a falling edge before the first increment [R07]
  wire ext_mode = clock_source_select[1];
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_armed <= 1'b0;
    end else if (!ext_mode || !timer_on) begin
      ext_armed <= 1'b0;
    end else if (src_fall) begin
      ext_armed <= 1'b1;
    end
  end
  wire clk_edge = src_rise & (!ext_mode | ext_armed);

  // =========================================
  // prescaler, cleared while off so the first tick is aligned [R10]
  reg [2:0] pre_cnt;
  reg pre_tick;
  always @* begin
    case (input_prescale_select)
      2'h0: pre_tick = clk_edge;
      2'h1: pre_tick = clk_edge & (pre_cnt[0] == 1'b1);
      2'h2: pre_tick = clk_edge & (pre_cnt[1:0] == 2'h3);
      2'h3: pre_tick = clk_edge & (pre_cnt == 3'h7);
      default: pre_tick = 1'b0;
    endcase
  end
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 3'h0;
    end else if (!timer_on) begin
      pre_cnt <= 3'h0;
    end else if (clk_edge) begin
      pre_cnt <= pre_cnt + 3'h1;
    end
  end

  // =========================================
  // gate source mux; the 8-bit overflow arrives as a rising pulse [R20] [R26]
  reg gsrc;
  reg gsrc_rise;
  always @* begin
    case (gate_source_select)
      `GSTMR_GS_PIN: begin
        gsrc = gpin_lvl;
        gsrc_rise = gpin_rise;
      end
      `GSTMR_GS_T8OVF: begin
        gsrc = t8_lvl;
        gsrc_rise = t8_rise;
      end
      `GSTMR_GS_PMATCH: begin
        gsrc = pm_lvl;
        gsrc_rise = pm_rise;
      end
      `GSTMR_GS_P10: begin
        gsrc = p10_lvl;
        gsrc_rise = p10_rise;
      end
      default: begin
        gsrc = 1'b0;
        gsrc_rise = 1'b0;
      end
    endcase
  end

  // toggle flop, held clear when toggle mode or timer is off [R13] [R16]
  reg gate_toggle;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_toggle <= 1'b0;
    end else if (!gate_toggle_mode || !timer_on) begin
      gate_toggle <= 1'b0;
    end else if (gsrc_rise) begin
      gate_toggle <= ~gate_toggle;
    end
  end

  // polarity applied after optional toggle [R15]
  wire gate_stage = gate_toggle_mode ? gate_toggle : gsrc;
  wire gate_active = gate_polarity ? gate_stage : ~gate_stage;

  // single pulse: armed by go, opened on active edge, done on trailing edge [R17] [R18] [R23]
  reg sp_open;
  reg gate_active_last;
  wire sp_lead = gate_active & ~gate_active_last;
  wire sp_trail = ~gate_active & gate_active_last;
  wire go_done = gate_ctrl[`GSTMR_GO_BIT];
  wire gate_value = gate_single_pulse_mode ? (gate_active & sp_open) : gate_active;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_open <= 1'b0;
      gate_active_last <= 1'b0;
    end else begin
      gate_active_last <= gate_active;
      if (!gate_single_pulse_mode || !go_done) begin
        sp_open <= 1'b0;
      end else if (sp_lead) begin
        sp_open <= 1'b1;
      end
    end
  end
  wire sp_done = gate_single_pulse_mode & go_done & sp_open & sp_trail;

  // gate value status and falling edge event [R19] [R24]
  reg gval;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gval <= 1'b0;
    end else begin
      gval <= gate_value;
    end
  end
  wire gate_fall = gval & ~gate_value;

  // count qualifier [R13] [R14]
  wire count_en = timer_on & (!gate_enable | gate_value);
  wire inc = count_en & pre_tick;

  // =========================================
  // register decode
  wire wr_ctrl = reg_wr && (reg_addr == `GSTMR_ADDR_CTRL);
  wire wr_gate = reg_wr && (reg_addr == `GSTMR_ADDR_GATE);
  wire wr_lo = reg_wr && (reg_addr == `GSTMR_ADDR_CNT_LO);
  wire wr_hi = reg_wr && (reg_addr == `GSTMR_ADDR_CNT_HI);
  wire wr_flags = reg_wr && (reg_addr == `GSTMR_ADDR_FLAGS);
  wire cmp_match = (counter_pair == cmp_pair);
  wire special = ccp_ctrl[`GSTMR_CCP_CMP_EN] & ccp_ctrl[`GSTMR_CCP_SPECIAL] & cmp_match;

  // control registers, control bit 1 and gate bit 2 never stored [R21] [R22]
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `GSTMR_RST_BYTE;
      gate_ctrl <= `GSTMR_RST_BYTE;
      cmp_pair <= `GSTMR_RST_WORD;
      ccp_ctrl <= 3'h0;
      secondary_osc_enable <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata & 8'hFD;
      end
      secondary_osc_enable <= ctrl[`GSTMR_SOSC_BIT]; // [R11]
      if (wr_gate) begin
        gate_ctrl <= {reg_wdata[7:3], 1'b0, reg_wdata[1:0]};
      end else if (sp_done || !gate_single_pulse_mode) begin
        gate_ctrl[`GSTMR_GO_BIT] <= 1'b0; // hardware clear [R18] [R23]
      end
      if (reg_wr && reg_addr == `GSTMR_ADDR_CMP_LO) begin
        cmp_pair[7:0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `GSTMR_ADDR_CMP_HI) begin
        cmp_pair[15:8] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `GSTMR_ADDR_CCP) begin
        ccp_ctrl <= reg_wdata[2:0];
      end
    end
  end

  // counter: byte write beats trigger, trigger clear has no overflow [R03] [R04] [R05] [R25] [R27]
  // trigger only reliable with synced instruction clock, software's duty [R06]
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_pair <= `GSTMR_RST_WORD;
    end else if (wr_lo || wr_hi) begin
      if (wr_lo) begin
        counter_pair[7:0] <= reg_wdata;
      end
      if (wr_hi) begin
        counter_pair[15:8] <= reg_wdata;
      end
    end else if (special) begin
      counter_pair <= `GSTMR_RST_WORD;
    end else if (inc) begin
      counter_pair <= counter_pair + 16'h0001;
    end
  end
  wire rollover = inc & !wr_lo & !wr_hi & !special & (counter_pair == 16'hFFFF);

  // sticky overflow and gate event flags, set wins over write-one-to-clear; compare event follows the match [R24] [R25]
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
      gate_event_flag <= 1'b0;
      compare_event <= 1'b0;
      capture_value <= `GSTMR_RST_WORD;
    end else begin
      overflow_flag <= rollover | (overflow_flag & ~(wr_flags & reg_wdata[`GSTMR_OVF_BIT]));
      gate_event_flag <= gate_fall | (gate_event_flag & ~(wr_flags & reg_wdata[`GSTMR_GEV_BIT]));
      compare_event <= ccp_ctrl[`GSTMR_CCP_CMP_EN] & cmp_match; // [R02]
      if (ccp_ctrl[`GSTMR_CCP_CAP_EN] && cap_rise) begin
        capture_value <= counter_pair; // [R01]
      end
    end
  end

  // =========================================
  // read data one cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `GSTMR_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `GSTMR_ADDR_CTRL: reg_rdata <= ctrl & 8'hFD; // [R22]
        `GSTMR_ADDR_GATE: reg_rdata <= {gate_ctrl[7:3], gval, gate_ctrl[1:0]}; // [R19]
        `GSTMR_ADDR_CNT_LO: reg_rdata <= counter_pair[7:0];
        `GSTMR_ADDR_CNT_HI: reg_rdata <= counter_pair[15:8];
        `GSTMR_ADDR_CMP_LO: reg_rdata <= cmp_pair[7:0];
        `GSTMR_ADDR_CMP_HI: reg_rdata <= cmp_pair[15:8];
        `GSTMR_ADDR_FLAGS: reg_rdata <= {5'h00, compare_event, gate_event_flag, overflow_flag};
        `GSTMR_ADDR_CCP: reg_rdata <= {5'h00, ccp_ctrl};
        default: reg_rdata <= `GSTMR_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `GSTMR_RST_BYTE;
    end
  end
endmodule
`default_nettype wire

/* File: common/gstmr_consts.vh */
// register offsets, field positions, reset values and timing counts of the gated timer
`ifndef GSTMR_CONSTS_VH
`define GSTMR_CONSTS_VH
// register offsets
`define GSTMR_ADDR_CTRL 4'h0
`define GSTMR_ADDR_GATE 4'h1
`define GSTMR_ADDR_CNT_LO 4'h2
`define GSTMR_ADDR_CNT_HI 4'h3
`define GSTMR_ADDR_CMP_LO 4'h4
`define GSTMR_ADDR_CMP_HI 4'h5
`define GSTMR_ADDR_FLAGS 4'h6
`define GSTMR_ADDR_CCP 4'h7
// control register fields
`define GSTMR_CS_HI 7
`define GSTMR_CS_LO 6
`define GSTMR_PS_HI 5
`define GSTMR_PS_LO 4
`define GSTMR_SOSC_BIT 3
`define GSTMR_SYNC_BIT 2
`define GSTMR_ON_BIT 0
// gate register fields
`define GSTMR_GE_BIT 7
`define GSTMR_GPOL_BIT 6
`define GSTMR_GTM_BIT 5
`define GSTMR_GSPM_BIT 4
`define GSTMR_GO_BIT 3
`define GSTMR_GVAL_BIT 2
`define GSTMR_GSS_HI 1
`define GSTMR_GSS_LO 0
// flag register fields (overflow and gate event write one to clear)
`define GSTMR_OVF_BIT 0
`define GSTMR_GEV_BIT 1
`define GSTMR_CMP_BIT 2
// capture/compare control fields
`define GSTMR_CCP_CMP_EN 0
`define GSTMR_CCP_SPECIAL 1
`define GSTMR_CCP_CAP_EN 2
// clock source codes
`define GSTMR_CS_INSTR 2'h0
`define GSTMR_CS_SYS 2'h1
`define GSTMR_CS_EXT 2'h2
`define GSTMR_CS_SENSE 2'h3
// gate source codes
`define GSTMR_GS_PIN 2'h0
`define GSTMR_GS_T8OVF 2'h1
`define GSTMR_GS_PMATCH 2'h2
`define GSTMR_GS_P10 2'h3
// reset values
`define GSTMR_RST_BYTE 8'h00
`define GSTMR_RST_WORD 16'h0000
// instruction clock is system clock divided by four
`define GSTMR_INSTR_DIV 2'h3
`endif

/* File: hw/gstmr_edge_sync.v */
// two-stage synchroniser with rising and falling edge pulses
`default_nettype none
module gstmr_edge_sync (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // asynchronous level in
  input wire async_in,
  // synchronised level and edges out
  output reg level,
  output wire rise,
  output wire fall
);
  reg meta;
  reg last;

  // =========================================
  // meta is read by level only, edges come from later stages
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      level <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= async_in;
      level <= meta;
      last <= level;
    end
  end

  assign rise = level & ~last;
  assign fall = ~level & last;
endmodule
`default_nettype wire

/* File: verification/gstmr_ccp_model.sv */
// capture unit stand-in that raises capture events for the timer
`default_nettype none
module gstmr_ccp_model (
  // clock
  input wire logic sys_clk,
  // event toward the timer
  output logic capture_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // event level, idle low until asked for
  initial capture_event = 1'b0;
  // hold several cycles so the two-flop synchroniser cannot miss it
  task automatic fire(input int hold);
    capture_event <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    capture_event <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: verification/gstmr_timer_monitor.sv */
// concurrent checks on the gated timer ports
`default_nettype none
module gstmr_timer_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register writes
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // time base outputs
  input wire logic [15:0] counter_pair,
  input wire logic [15:0] capture_value,
  input wire logic overflow_flag,
  input wire logic gate_event_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // one clock domain, the raw reset disables every check
  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  cnt_lo_write_a: assert property (
    reg_wr && reg_addr == 4'h2 |=> counter_pair[7:0] == $past(reg_wdata))
    else $error("counter low byte write lost");
  cnt_hi_write_a: assert property (
    reg_wr && reg_addr == 4'h3 |=> counter_pair[15:8] == $past(reg_wdata))
    else $error("counter high byte write lost");
  count_step_a: assert property (
    !$past(reg_wr) && counter_pair != $past(counter_pair)
    |-> counter_pair == $past(counter_pair) + 16'h0001 || counter_pair == 16'h0000)
    else $error("counter jumped by more than one");
  rollover_flag_a: assert property (
    $past(counter_pair) == 16'hffff && counter_pair == 16'h0000 |-> ##[0:2] overflow_flag)
    else $error("rollover without overflow flag");
  clear_no_ovf_a: assert property (
    $rose(overflow_flag) |-> $past(counter_pair) == 16'hffff || $past(counter_pair, 2) == 16'hffff)
    else $error("overflow flag without rollover");
  ovf_sticky_a: assert property (
    overflow_flag && !(reg_wr && reg_addr == 4'h6 && reg_wdata[0]) |=> overflow_flag)
    else $error("overflow flag dropped by itself");
  gev_sticky_a: assert property (
    gate_event_flag && !(reg_wr && reg_addr == 4'h6 && reg_wdata[1]) |=> gate_event_flag)
    else $error("gate event flag dropped by itself");
  capture_copy_a: assert property (
    capture_value != $past(capture_value)
    |-> capture_value == $past(counter_pair) || capture_value == counter_pair)
    else $error("captured value not a counter value");
endmodule
bind gstmr_timer gstmr_timer_monitor gstmr_timer_monitor_inst (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .counter_pair(counter_pair), .capture_value(capture_value),
  .overflow_flag(overflow_flag), .gate_event_flag(gate_event_flag)
);
`default_nettype wire

/* File: verification/gstmr_timer_tb.sv */
// self-checking bench of the gated sixteen bit timer
`default_nettype none
module gstmr_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_pin = 1'b0;
  logic xtal = 1'b0;
  logic sense = 1'b0;
  logic [3:0] gsrc = 4'h0;
  logic [7:0] reg_rdata, d;
  logic cap_ev, osc_en, cmp_ev, ovf, gev;
  logic [15:0] cnt, cap, c;
  int errors = 0;
  int checks = 0;
  int n, m;
  int src[4] = '{0, 1, 2, 3};
  logic [7:0] cfg[4] = '{8'h81, 8'h89, 8'hc1, 8'h85};
  // ========================================
  // design, far-side model and clock
  gstmr_timer gstmr_timer_inst (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_clock_pin(ext_pin), .crystal_clk(xtal), .sensing_oscillator(sense),
    .secondary_osc_enable(osc_en), .gate_pin(gsrc[0]), .timer8_overflow(gsrc[1]),
    .period_match(gsrc[2]), .period10_match(gsrc[3]), .capture_event(cap_ev),
    .counter_pair(cnt), .capture_value(cap), .compare_event(cmp_ev),
    .overflow_flag(ovf), .gate_event_flag(gev)
  );
  gstmr_ccp_model gstmr_ccp_model_inst (.sys_clk(sys_clk), .capture_event(cap_ev));
  always #5 sys_clk = ~sys_clk;
  // ========================================
  // verdict, comparisons and bus cycles
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // tolerance covers synchroniser and prescaler phase
  task automatic near(input logic [15:0] got, input int exp, input int tol, input string what);
    checks++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) + tol < exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask
  // bytes are read low first; callers stop the timer or close the gate, except the active low gate check
  task automatic rd_cnt(output logic [15:0] v);
    logic [7:0] lo, hi;
    rd(4'h2, lo);
    rd(4'h3, hi);
    v = {hi, lo};
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic clr_cnt;
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
  endtask
  task automatic set_clk(input int k, input logic lv);
    case (k)
      1: xtal <= lv;
      2: sense <= lv;
      default: ext_pin <= lv;
    endcase
  endtask
  // ========================================
  // watchdog against a hung run
  initial begin
    #900000;
    errors++;
    $display("Error at %0t: run timed out", $time);
    finish_test;
  end
  // ========================================
  // main sequence
  initial begin
    void'($urandom(39));
    cyc(12);
    rstn <= 1'b1;
    cyc(3);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      // gate value bit follows the live gate after reset, so it is left out
      near(a == 1 ? d & 8'hfb : d, 0, 0, "reset value");
    end
    m = $urandom;
    wr(4'h0, 8'(m) & 8'hfe);
    wr(4'h1, 8'(m >> 8) & 8'hf3);
    rd(4'h0, d);
    near(d, m & 8'hfc, 0, "control readback");
    near(16'(osc_en), m >> 3 & 1, 0, "oscillator enable");
    rd(4'h1, d);
    near(d & 8'hfb, m >> 8 & 8'hf3, 0, "gate readback");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h00);
    $display("registers done");
    for (int p = 0; p < 5; p++) begin
      n = 40 + $urandom_range(60);
      clr_cnt();
      wr(4'h0, p < 4 ? 8'h41 | 8'(p << 4) : 8'h01);
      cyc(n);
      wr(4'h0, 8'h40);
      rd_cnt(c);
      near(c, (n + 2) / (p < 4 ? 1 << p : 4), 2, "prescaled count");
    end
    $display("prescaler done");
    wr(4'h2, 8'hfd);
    wr(4'h3, 8'hff);
    wr(4'h0, 8'h41);
    cyc(6);
    wr(4'h0, 8'h40);
    rd_cnt(c);
    near(c, 5, 1, "count after rollover");
    rd(4'h6, d);
    near(d & 8'h01, 1, 0, "overflow flag set");
    wr(4'h6, 8'h03);
    rd(4'h6, d);
    near(d & 8'h03, 0, 0, "flags cleared");
    $display("rollover done");
    clr_cnt();
    wr(4'h1, 8'hc0);
    wr(4'h0, 8'h41);
    cyc(10);
    rd_cnt(c);
    near(c, 0, 0, "closed gate holds");
    // polarity change above may have raised the gate event flag already
    wr(4'h6, 8'h03);
    gsrc[0] <= 1'b1;
    cyc(20);
    rd(4'h1, d);
    near(d[2], 1, 0, "gate value high");
    gsrc[0] <= 1'b0;
    cyc(6);
    rd_cnt(c);
    near(c, 22, 5, "open gate count");
    near(16'(gev), 1, 0, "gate event flag");
    wr(4'h1, 8'h80);
    cyc(10);
    rd_cnt(c);
    near(c, 22 + 14, 6, "active low gate counts");
    wr(4'h0, 8'h40);
    wr(4'h6, 8'h03);
    foreach (src[i]) begin
      wr(4'h1, 8'h40 | 8'(src[i]));
      gsrc[src[i]] <= 1'b1;
      cyc(5);
      rd(4'h1, d);
      near(d[2], 1, 0, "selected gate source");
      gsrc[src[i]] <= 1'b0;
      cyc(5);
      rd(4'h1, d);
      near(d[2], 0, 0, "selected gate source low");
    end
    // toggle mode: one pin pulse keeps the gate open until the next one
    clr_cnt();
    wr(4'h1, 8'he0);
    wr(4'h0, 8'h41);
    gsrc[0] <= 1'b1;
    cyc(4);
    gsrc[0] <= 1'b0;
    cyc(6);
    rd(4'h1, d);
    near(d[2], 1, 0, "toggle holds gate open");
    wr(4'h0, 8'h40);
    cyc(2);
    rd(4'h1, d);
    near(d[2], 0, 0, "timer off clears toggle");
    $display("gate done");
    wr(4'h6, 8'h03);
    clr_cnt();
    wr(4'h4, 8'h10);
    wr(4'h5, 8'h00);
    wr(4'h7, 8'h03);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h41);
    m = 0;
    n = 0;
    repeat (100) begin
      @(posedge sys_clk);
      #1;
      if (cnt > m) m = cnt;
      if (cmp_ev === 1'b1) n++;
    end
    @(posedge sys_clk);
    wr(4'h0, 8'h40);
    wr(4'h7, 8'h00);
    near(16'(m), 16, 0, "compare pair is the period");
    near(16'(n), 6, 1, "compare events");
    near(16'(ovf), 0, 0, "no overflow from clearing");
    $display("special trigger done");
    m = $urandom;
    wr(4'h2, 8'(m));
    wr(4'h3, 8'(m >> 8));
    wr(4'h7, 8'h04);
    gstmr_ccp_model_inst.fire(4);
    cyc(4);
    near(cap, m & 16'hffff, 0, "captured value");
    wr(4'h7, 8'h00);
    $display("capture done");
    for (int k = 0; k < 4; k++) begin
      clr_cnt();
      wr(4'h0, cfg[k]);
      repeat (5) begin
        set_clk(k, 1'b1);
        cyc(4);
        set_clk(k, 1'b0);
        cyc(4);
      end
      cyc(6);
      near(16'(osc_en), cfg[k] >> 3 & 1, 0, "oscillator follows bit");
      wr(4'h0, cfg[k] & 8'hfe);
      rd_cnt(c);
      near(c, 4, 0, "edges counted");
    end
    $display("external clocks done");
    clr_cnt();
    wr(4'h1, 8'hd8);
    wr(4'h0, 8'h41);
    rd(4'h1, d);
    near(d[3], 1, 0, "acquisition armed");
    repeat (2) begin
      gsrc[0] <= 1'b1;
      cyc(10);
      gsrc[0] <= 1'b0;
      cyc(6);
      rd(4'h1, d);
      near(d[3], 0, 0, "acquisition done");
      rd_cnt(c);
      near(c, 10, 3, "single pulse count");
    end
    wr(4'h0, 8'h40);
    $display("single pulse done");
    finish_test;
  end
endmodule
`default_nettype wire
